// [hdl/phmp_port.sv]
`default_nettype none
module phmp_port (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic chip_sel_n,
    input wire logic data_strobe_n,
    input wire logic direction_select,
    input wire logic [1:0] reg_select,
    input wire logic [7:0] host_bus_i,
    output logic [7:0] host_bus_o,
    output logic host_bus_oe,
    output logic host_attention_n,
    input wire logic notify_enable,
    input wire logic boot_mode,
    input wire logic dsp_msg_wr,
    input wire logic [7:0] dsp_msg_wdata,
    input wire logic dsp_msg_take,
    output logic [7:0] dsp_msg_rdata,
    output logic inbound_byte_pending,
    output logic outbound_byte_ready,
    output logic boot_triplet_done,
    output logic response_done,
    output logic pcm_wr_valid,
    output logic [7:0] pcm_wr_data,
    output logic compressed_wr_valid,
    output logic [7:0] compressed_wr_data,
    input wire logic pcm_fifo_near_full,
    input wire logic compressed_fifo_near_full
);
    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------
    logic [phmp_pkg::SYNC_WIDTH-1:0] pins_s;
    logic cs_n_s;
    logic ds_n_s;
    logic dir_s;
    logic [1:0] sel_s;
    logic [7:0] bus_s;
    logic active;
    logic write_end;
    logic read_end;
    phmp_pkg::phmp_state_t state_q;
    logic [7:0] outbound_q;
    logic [7:0] status_byte;
    logic [1:0] boot_cnt_q;
    logic [2:0] resp_cnt_q;

    phmp_sync #(
        .WIDTH(phmp_pkg::SYNC_WIDTH)
    ) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .async_in({chip_sel_n, data_strobe_n, direction_select, reg_select, host_bus_i}),
        .sync_out(pins_s)
    );

    assign {cs_n_s, ds_n_s, dir_s, sel_s, bus_s} = pins_s;
    assign active = !cs_n_s && !ds_n_s;
    assign write_end = (state_q == phmp_pkg::PHMP_WRITE) && !active;
    assign read_end = (state_q == phmp_pkg::PHMP_READ) && !active;

    // ---------------------------------------------------------------
    // Host cycle tracking
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q <= phmp_pkg::PHMP_IDLE;
        end
        else if (ce)
        begin
            case (state_q)
                phmp_pkg::PHMP_IDLE:
                begin
                    if (active && dir_s)
                    begin
                        state_q <= phmp_pkg::PHMP_READ;
                    end
                    else if (active)
                    begin
                        state_q <= phmp_pkg::PHMP_WRITE;
                    end
                end
                phmp_pkg::PHMP_READ,
                phmp_pkg::PHMP_WRITE:
                begin
                    if (!active)
                    begin
                        state_q <= phmp_pkg::PHMP_IDLE;
                    end
                end
                default:
                begin
                    state_q <= phmp_pkg::PHMP_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Inbound message byte
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dsp_msg_rdata <= phmp_pkg::BYTE_RESET;
            inbound_byte_pending <= 1'b0;
        end
        else if (ce)
        begin
            if (write_end && sel_s == phmp_pkg::SEL_MESSAGE)
            begin
                dsp_msg_rdata <= bus_s;
                inbound_byte_pending <= 1'b1;
            end
            else if (dsp_msg_take)
            begin
                inbound_byte_pending <= 1'b0;
            end
        end
    end

    // Boot handshake: every third inbound byte in boot
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            boot_cnt_q <= 2'h0;
            boot_triplet_done <= 1'b0;
        end
        else if (ce)
        begin
            boot_triplet_done <= 1'b0;
            if (!boot_mode)
            begin
                boot_cnt_q <= 2'h0;
            end
            else if (write_end && sel_s == phmp_pkg::SEL_MESSAGE)
            begin
                if (boot_cnt_q == phmp_pkg::BOOT_LAST_BYTE)
                begin
                    boot_cnt_q <= 2'h0;
                    boot_triplet_done <= 1'b1;
                end
                else
                begin
                    boot_cnt_q <= boot_cnt_q + 2'h1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Outbound message byte
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            outbound_q <= phmp_pkg::BYTE_RESET;
            outbound_byte_ready <= 1'b0;
        end
        else if (ce)
        begin
            if (dsp_msg_wr)
            begin
                outbound_q <= dsp_msg_wdata;
                outbound_byte_ready <= 1'b1;
            end
            else if (read_end && sel_s == phmp_pkg::SEL_MESSAGE)
            begin
                outbound_byte_ready <= 1'b0;
            end
        end
    end

    // Run-time response length counter
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            resp_cnt_q <= 3'h0;
            response_done <= 1'b0;
        end
        else if (ce)
        begin
            response_done <= 1'b0;
            if (boot_mode)
            begin
                resp_cnt_q <= 3'h0;
            end
            else if (read_end && sel_s == phmp_pkg::SEL_MESSAGE && outbound_byte_ready)
            begin
                if (resp_cnt_q == phmp_pkg::RESPONSE_LAST_BYTE)
                begin
                    resp_cnt_q <= 3'h0;
                    response_done <= 1'b1;
                end
                else
                begin
                    resp_cnt_q <= resp_cnt_q + 3'h1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data and attention
    // ---------------------------------------------------------------
    always_comb
    begin
        status_byte = phmp_pkg::BYTE_RESET;
        status_byte[phmp_pkg::BIT_OUTBOUND_READY] = outbound_byte_ready;
        status_byte[phmp_pkg::BIT_INBOUND_PENDING] = inbound_byte_pending;
        status_byte[phmp_pkg::BIT_PCM_NEAR_FULL] = pcm_fifo_near_full;
        status_byte[phmp_pkg::BIT_COMPRESSED_NEAR_FULL] = compressed_fifo_near_full;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            host_bus_o <= phmp_pkg::BYTE_RESET;
            host_bus_oe <= 1'b0;
            host_attention_n <= 1'b1;
        end
        else if (ce)
        begin
            host_bus_oe <= active && dir_s;
            case (sel_s)
                phmp_pkg::SEL_MESSAGE: host_bus_o <= outbound_q;
                phmp_pkg::SEL_STATUS: host_bus_o <= status_byte;
                default: host_bus_o <= phmp_pkg::BYTE_RESET;
            endcase
            host_attention_n <= !(outbound_byte_ready && notify_enable
                && !boot_mode);
        end
    end

    // ---------------------------------------------------------------
    // Audio input routing
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pcm_wr_valid <= 1'b0;
            pcm_wr_data <= phmp_pkg::BYTE_RESET;
            compressed_wr_valid <= 1'b0;
            compressed_wr_data <= phmp_pkg::BYTE_RESET;
        end
        else if (ce)
        begin
            pcm_wr_valid <= write_end && sel_s == phmp_pkg::SEL_PCM;
            compressed_wr_valid <= write_end && sel_s == phmp_pkg::SEL_COMPRESSED;
            if (write_end && sel_s == phmp_pkg::SEL_PCM)
            begin
                pcm_wr_data <= bus_s;
            end
            if (write_end && sel_s == phmp_pkg::SEL_COMPRESSED)
            begin
                compressed_wr_data <= bus_s;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    attn_notify_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && outbound_byte_ready && notify_enable && !boot_mode |=> !host_attention_n)
        else $error("attention not asserted for waiting byte");
    attn_boot_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && boot_mode |=> host_attention_n)
        else $error("attention asserted during boot");
    inb_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && write_end && sel_s == phmp_pkg::SEL_MESSAGE |=> inbound_byte_pending)
        else $error("pending not set by host write");
    inb_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
        inbound_byte_pending && !dsp_msg_take |=> inbound_byte_pending)
        else $error("pending dropped before take");
    outb_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && dsp_msg_wr |=> outbound_byte_ready && outbound_q == $past(dsp_msg_wdata))
        else $error("ready not set by internal write");
    outb_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && read_end && sel_s == phmp_pkg::SEL_MESSAGE && !dsp_msg_wr
        |=> !outbound_byte_ready)
        else $error("ready not cleared by host read");
    read_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && active && dir_s && sel_s == phmp_pkg::SEL_STATUS
        |=> host_bus_oe && host_bus_o == $past(status_byte))
        else $error("status not driven on read");
    write_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && !dir_s |=> !host_bus_oe)
        else $error("bus driven during write");
    pcm_route_a: assert property (@(posedge ref_clk) disable iff (srst)
        ce && write_end && sel_s == phmp_pkg::SEL_PCM
        |=> pcm_wr_valid && pcm_wr_data == $past(bus_s) && !compressed_wr_valid)
        else $error("pcm byte not routed");
    resp_len_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(response_done) |-> $past(resp_cnt_q) == phmp_pkg::RESPONSE_LAST_BYTE)
        else $error("response ended at wrong length");
endmodule
`default_nettype wire

// [hdl/phmp_pkg.sv]
// Summary of operation
// - Attention low while outbound byte waits
// - Attention active low, covers unsolicited messages
// - Select code picks one of four registers
// - Only message and status registers read
// - Device drives selected register during reads
// - Pending stays set until byte taken
// - Boot handshake: three bytes in, one out
// - Run-time responses are six bytes
// - No attention during boot
// - Ready bit one marks valid message byte
// - Pending set on host write, cleared on take
// - Ready set on internal write, cleared on read
// - Audio bytes go to FIFOs, near-full flags
`default_nettype none
package phmp_pkg;
    // ---------------------------------------------------------------
    // Register select codes
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_MESSAGE = 2'h0;
    localparam logic [1:0] SEL_STATUS = 2'h1;
    localparam logic [1:0] SEL_PCM = 2'h2;
    localparam logic [1:0] SEL_COMPRESSED = 2'h3;
    // ---------------------------------------------------------------
    // Status register fields
    // ---------------------------------------------------------------
    localparam int BIT_OUTBOUND_READY = 1;
    localparam int BIT_INBOUND_PENDING = 2;
    localparam int BIT_COMPRESSED_NEAR_FULL = 4;
    localparam int BIT_PCM_NEAR_FULL = 5;
    // ---------------------------------------------------------------
    // Reset values and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] BOOT_LAST_BYTE = 2'h2;
    localparam logic [2:0] RESPONSE_LAST_BYTE = 3'h5;
    localparam int SYNC_WIDTH = 13;
    // ---------------------------------------------------------------
    // Host cycle states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PHMP_IDLE = 3'h1,
        PHMP_READ = 3'h2,
        PHMP_WRITE = 3'h4
    } phmp_state_t;
endpackage
`default_nettype wire

// [hdl/phmp_sync.sv]
`default_nettype none
module phmp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // Two flops per bit; first stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_q <= '1;
            sync_out <= '1;
        end
        else if (ce)
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [test/phmp_host.sv]
`default_nettype none
module phmp_host (
    input wire logic ref_clk,
    output logic chip_sel_n,
    output logic data_strobe_n,
    output logic direction_select,
    output logic [1:0] reg_select,
    output logic [7:0] host_bus_i,
    input wire logic [7:0] host_bus_o,
    input wire logic host_bus_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] drv_q = 8'h00;
    logic drv_en = 1'b0;
    // ------------------------------------------------
    // Bus wire: released lines show the inverted last value
    // ------------------------------------------------
    assign host_bus_i = host_bus_oe ? host_bus_o : (drv_en ? drv_q : ~drv_q);
    initial
    begin
        chip_sel_n = 1'b1;
        data_strobe_n = 1'b1;
        direction_select = 1'b1;
        reg_select = 2'h1;
    end
    // ------------------------------------------------
    // One byte cycle
    // ------------------------------------------------
    task cycle(input logic dir, input logic [1:0] sel, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge ref_clk);
        #1;
        reg_select = sel;
        direction_select = dir;
        drv_q = d;
        drv_en = !dir;
        @(posedge ref_clk);
        #1;
        chip_sel_n = 1'b0;
        data_strobe_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        q = host_bus_i;
        chip_sel_n = 1'b1;
        data_strobe_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        drv_en = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task wr_msg(input logic [7:0] d);
        logic [7:0] s;
        int n;
        n = 0;
        s = 8'hFF;
        while (s[2] !== 1'b0 && n < 50)
        begin
            cycle(1'b1, 2'h1, 8'h00, s);
            n++;
        end
        cycle(1'b0, 2'h0, d, s);
    endtask
    task rd_msg(output logic [7:0] q);
        logic [7:0] s;
        int n;
        n = 0;
        s = 8'h00;
        while (s[1] !== 1'b1 && n < 50)
        begin
            cycle(1'b1, 2'h1, 8'h00, s);
            n++;
        end
        cycle(1'b1, 2'h0, 8'h00, q);
    endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cs_n, ds_n, dir, ntf = 1'b0, boot = 1'b0, dwr = 1'b0, dtake = 1'b0;
    logic pnf = 1'b0, cnf = 1'b0, oe, att_n, pend, rdy, bdone, rdone, pv, cv, ce = 1'b1;
    logic [1:0] sel;
    logic [7:0] bi, bo, dwd = 8'h00, drd, pd, cd, q, pcm_d, cmp_d;
    int fails = 0, n_compared = 0, cyc = 0, n_pcm = 0, n_cmp = 0, n_boot = 0, n_resp = 0;
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    phmp_port phmp_port_inst (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .chip_sel_n(cs_n), .data_strobe_n(ds_n), .direction_select(dir),
        .reg_select(sel), .host_bus_i(bi), .host_bus_o(bo), .host_bus_oe(oe),
        .host_attention_n(att_n), .notify_enable(ntf), .boot_mode(boot),
        .dsp_msg_wr(dwr), .dsp_msg_wdata(dwd), .dsp_msg_take(dtake),
        .dsp_msg_rdata(drd), .inbound_byte_pending(pend), .outbound_byte_ready(rdy),
        .boot_triplet_done(bdone), .response_done(rdone), .pcm_wr_valid(pv),
        .pcm_wr_data(pd), .compressed_wr_valid(cv), .compressed_wr_data(cd),
        .pcm_fifo_near_full(pnf), .compressed_fifo_near_full(cnf));
    phmp_host phmp_host_inst (.ref_clk(ref_clk), .chip_sel_n(cs_n),
        .data_strobe_n(ds_n), .direction_select(dir), .reg_select(sel),
        .host_bus_i(bi), .host_bus_o(bo), .host_bus_oe(oe));
    // ------------------------------------------------
    // Pulse monitors and timeout
    // ------------------------------------------------
    always @(posedge ref_clk)
    begin
        cyc++;
        if (pv === 1'b1)
        begin
            n_pcm++;
            pcm_d = pd;
        end
        if (cv === 1'b1)
        begin
            n_cmp++;
            cmp_d = cd;
        end
        if (bdone === 1'b1) n_boot++;
        if (rdone === 1'b1) n_resp++;
        if (cyc > 30000)
        begin
            fails++;
            stop_test();
        end
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task dsp(input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        dwr = w;
        dtake = !w;
        dwd = d;
        @(posedge ref_clk);
        #1;
        dwr = 1'b0;
        dtake = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task rd(input logic [1:0] s);
        phmp_host_inst.cycle(1'b1, s, 8'h00, q);
    endtask
    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk("attention", 8'h01, {7'h0, att_n});
        rd(2'h1);
        chk("status reset", 8'h00, q);
        rd(2'h2);
        chk("pcm read", 8'h00, q);
        rd(2'h3);
        chk("cmp read", 8'h00, q);
        $display("test reset done");
        phmp_host_inst.wr_msg(8'hA5);
        repeat (20) @(posedge ref_clk);
        chk("rdata", 8'hA5, drd);
        rd(2'h1);
        chk("pending", 8'h04, q);
        dsp(1'b0, 8'h00);
        chk("taken", 8'h00, {7'h0, pend});
        $display("test inbound done");
        boot = 1'b1;
        ntf = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            phmp_host_inst.wr_msg(8'h12 + 8'(i));
            chk("boot byte", 8'h12 + 8'(i), drd);
            dsp(1'b0, 8'h00);
        end
        chk("boot done", 8'h01, 8'(n_boot));
        dsp(1'b1, 8'h5A);
        chk("boot attention", 8'h01, {7'h0, att_n});
        phmp_host_inst.rd_msg(q);
        chk("boot response", 8'h5A, q);
        $display("test boot done");
        boot = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            dsp(1'b1, 8'hC0 + 8'(i));
            chk("attention low", 8'h00, {7'h0, att_n});
            rd(2'h1);
            chk("ready", 8'h02, q);
            phmp_host_inst.rd_msg(q);
            chk("resp byte", 8'hC0 + 8'(i), q);
            chk("ready clear", 8'h00, {7'h0, rdy});
        end
        chk("resp done", 8'h01, 8'(n_resp));
        dsp(1'b1, 8'h77);
        repeat (10000) @(posedge ref_clk);
        rd(2'h1);
        chk("unsolicited", 8'h02, q);
        phmp_host_inst.rd_msg(q);
        chk("unsol byte", 8'h77, q);
        ntf = 1'b0;
        dsp(1'b1, 8'h66);
        chk("no notify", 8'h01, {7'h0, att_n});
        phmp_host_inst.rd_msg(q);
        chk("quiet byte", 8'h66, q);
        $display("test outbound done");
        phmp_host_inst.cycle(1'b0, 2'h2, 8'h3C, q);
        repeat (3) @(posedge ref_clk);
        chk("pcm count", 8'h01, 8'(n_pcm));
        chk("pcm data", 8'h3C, pcm_d);
        phmp_host_inst.cycle(1'b0, 2'h3, 8'hC3, q);
        repeat (3) @(posedge ref_clk);
        chk("cmp count", 8'h01, 8'(n_cmp));
        chk("cmp data", 8'hC3, cmp_d);
        #1;
        pnf = 1'b1;
        rd(2'h1);
        chk("pcm near", 8'h20, q);
        rd(2'h2);
        chk("pcm read busy", 8'h00, q);
        pnf = 1'b0;
        cnf = 1'b1;
        phmp_host_inst.cycle(1'b0, 2'h1, 8'hFF, q);
        rd(2'h1);
        chk("cmp near", 8'h10, q);
        rd(2'h3);
        chk("cmp read busy", 8'h00, q);
        cnf = 1'b0;
        ce = 1'b0;
        dsp(1'b1, 8'h99);
        chk("frozen ready", 8'h00, {7'h0, rdy});
        ce = 1'b1;
        $display("test audio done");
        stop_test();
    end
endmodule
`default_nettype wire
